// ===== common/fifo_flags_pkg.sv
// Constants shared by the status-flag and bus-matching FIFO core
`default_nettype none

package fifo_flags_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the APB slave
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_OFFSET = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_W    = 5;
  localparam int CTRL_FIRST_WORD_FALLTHROUGH = 0;  // first_word_fallthrough
  localparam int CTRL_SYNC = 1;  // flag_timing_select, high = synchronous
  localparam int CTRL_BE   = 2;  // byte_order_select
  localparam int CTRL_IW9  = 3;  // input_width_select, high = 9 bits
  localparam int CTRL_OW9  = 4;  // output_width_select, high = 9 bits
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Offset register fields: empty offset low half, full offset high half
  localparam int OFS_E_LSB = 0;
  localparam int OFS_F_LSB = 16;
  localparam int OFS_W     = 16;
  localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 16'h0007;
  localparam logic [OFS_W-1:0] FULL_OFS_RST  = 16'h0007;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int ST_EMPTY_N = 0;
  localparam int ST_FULL_N  = 1;
  localparam int ST_OR_N    = 2;
  localparam int ST_IR_N    = 3;
  localparam int ST_HF_N    = 4;
  localparam int ST_AE_N    = 5;
  localparam int ST_AF_N    = 6;
  localparam int ST_CNT_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry and counting
  localparam int DEPTH_DEF = 512;  // 18-bit word capacity
  localparam int CNT_W     = 17;   // width of all internal counts
  localparam int BYTE_W    = 9;
  localparam int WORD_W    = 18;

endpackage : fifo_flags_pkg

`default_nettype wire

// ===== core/fifo_flags_core.sv
// FIFO core: bus matching, empty/full/ready, half-full and almost flags, APB config
//
// Notes on behaviour
// - Standard mode: almost_empty_n low when stored words at most empty offset.
// - Fall-through mode: almost_empty_n low when words incl output register at most offset plus one.
// - Asynchronous almost-empty: asserted on read_clock edge, released on write_clock edge.
// - Synchronous almost-empty: set and released only on read_clock edges.
// - half_full_n falls on the write edge taking the count above half depth.
// - half_full_n rises on the read edge bringing pointer difference to half or less.
// - Standard mode: half_full_n falls after D/2 plus one writes.
// - Fall-through mode: half_full_n falls after (D-1)/2 plus two writes.
// - Depth is word capacity, doubled for 9-in 9-out, plus one in fall-through.
// - Read data uses all 18 output bits, or the low 9 in narrow output.
// - Wide to wide: byte order select high swaps upper and lower bytes.
// - Narrow in, wide out: two writes form a word, first byte placed by order.
// - Wide in, narrow out: a word leaves in two reads, order chosen by select.
// - full_n rises one write edge after a freeing read, or one later.
// - Fall-through: first word and output_ready_n low two read edges after write.
// - Synchronous almost_empty_n rises one read edge after the lifting write.
// - Fall-through: input_ready_n returns low one write edge after a freeing read.
// - Synchronous almost_full_n rises one write edge after the lowering read.
// - empty_n low when nothing stored; reads while empty are not taken.
// - full_n low when full in standard mode; writes while full are not taken.
`default_nettype none

module fifo_flags_core #(
  parameter int DEPTH = fifo_flags_pkg::DEPTH_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        write_clock,
  input  wire logic        read_clock,
  input  wire logic        write_enable_n,
  input  wire logic        read_enable_n,
  input  wire logic [17:0] data_in,
  input  wire logic        master_reset_n,
  input  wire logic        partial_reset_n,
  output logic      [17:0] data_out,
  output logic             empty_n,
  output logic             full_n,
  output logic             output_ready_n,
  output logic             input_ready_n,
  output logic             half_full_n,
  output logic             almost_empty_n,
  output logic             almost_full_n
);

  localparam int AW = $clog2(2 * DEPTH);
  localparam int PW = AW + 1;
  localparam int CW = fifo_flags_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0]                          wclk_s;
    logic [2:0]                          rclk_s;
    logic [1:0]                          wen_s;
    logic [1:0]                          ren_s;
    logic [1:0]                          mrs_s;
    logic [1:0]                          prs_s;
    logic [17:0]                         din_s1;
    logic [17:0]                         din_s2;
    logic [fifo_flags_pkg::CTRL_W-1:0]   ctrl;
    logic [fifo_flags_pkg::CTRL_W-1:0]   act;
    logic [fifo_flags_pkg::OFS_W-1:0]    e_ofs;
    logic [fifo_flags_pkg::OFS_W-1:0]    f_ofs;
    logic [PW-1:0]                       wr_ptr;
    logic [PW-1:0]                       rd_ptr;
    logic [PW-1:0]                       wr_gray;
    logic [PW-1:0]                       rd_gray;
    logic [PW-1:0]                       wg1;
    logic [PW-1:0]                       wg2;
    logic [PW-1:0]                       rg1;
    logic [PW-1:0]                       rg2;
    logic [8:0]                          pend;
    logic                                pend_v;
    logic                                rd_half;
    logic                                out_v;
    logic                                avail;
    logic [17:0]                         data_out;
    logic                                empty_n;
    logic                                full_n;
    logic                                or_n;
    logic                                ir_n;
    logic                                hf_n;
    logic                                ae_n;
    logic                                af_n;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
  } state_type;

  state_type s;
  state_type n;

  logic [17:0] mem [0:2*DEPTH-1];
  logic        mem_we;
  logic [17:0] mem_wdata;

  logic          wedge;
  logic          redge;
  logic          rst_fifo;
  logic          fw;
  logic          be;
  logic          iw9;
  logic          ow9;
  logic          synct;
  logic          split;
  logic          consume;
  logic          pop;
  logic          adv;
  logic          wr_take;
  logic [CW-1:0] cap;
  logic [CW-1:0] half;
  logic [CW-1:0] fw_c;
  logic [CW-1:0] ae_thr;
  logic [CW-1:0] af_thr;
  logic [CW-1:0] wcnt;
  logic [CW-1:0] wcnt_new;
  logic [CW-1:0] rcnt;
  logic [CW-1:0] rcnt_new;
  logic [CW-1:0] tcnt;
  logic [CW-1:0] mcnt;
  logic [PW-1:0] wr_new;
  logic [PW-1:0] rd_new;
  logic [PW-1:0] rbase;
  logic [17:0]   word;
  logic [17:0]   fmt;
  logic          outv_new;
  logic          hit;
  logic [31:0]   rd_mux;

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    n = s;
    mem_we = 1'b0;
    mem_wdata = 18'h00000;

    // Pins pass two flops; the third clock stage only feeds the edge detect
    n.wclk_s = {s.wclk_s[1:0], write_clock};
    n.rclk_s = {s.rclk_s[1:0], read_clock};
    n.wen_s  = {s.wen_s[0], write_enable_n};
    n.ren_s  = {s.ren_s[0], read_enable_n};
    n.mrs_s  = {s.mrs_s[0], master_reset_n};
    n.prs_s  = {s.prs_s[0], partial_reset_n};
    n.din_s1 = data_in;
    n.din_s2 = s.din_s1;
    wedge    = s.wclk_s[1] & ~s.wclk_s[2];
    redge    = s.rclk_s[1] & ~s.rclk_s[2];
    rst_fifo = ~s.mrs_s[1] | ~s.prs_s[1];

    fw    = s.act[fifo_flags_pkg::CTRL_FIRST_WORD_FALLTHROUGH];
    synct = s.act[fifo_flags_pkg::CTRL_SYNC];
    be    = s.act[fifo_flags_pkg::CTRL_BE];
    iw9   = s.act[fifo_flags_pkg::CTRL_IW9];
    ow9   = s.act[fifo_flags_pkg::CTRL_OW9];
    split = ow9 & ~iw9;
    fw_c  = {{(CW-1){1'b0}}, fw};
    cap   = (iw9 & ow9) ? CW'(2 * DEPTH) : CW'(DEPTH);
    half  = cap >> 1;
    ae_thr = CW'(s.e_ofs) + fw_c;
    af_thr = (cap > CW'(s.f_ofs)) ? cap - CW'(s.f_ofs) : '0;

    // Each side sees the other's pointer only after two register stages
    n.wg1 = s.wr_gray;
    n.wg2 = s.wg1;
    n.rg1 = s.rd_gray;
    n.rg2 = s.rg1;

    //////////////////////////////////////////////////////////////////////////
    // Write side
    wcnt    = CW'(PW'(s.wr_ptr - to_bin(s.rg2)));
    wr_take = wedge & ~s.wen_s[1] & (wcnt < cap) & ~rst_fifo;
    wr_new  = s.wr_ptr;
    if (wr_take)
    begin
      if (iw9 & ~ow9)
      begin
        if (!s.pend_v)
        begin
          n.pend   = s.din_s2[8:0];
          n.pend_v = 1'b1;
        end
        else
        begin
          // First byte lands high unless the order select swaps it
          mem_wdata = be ? {s.din_s2[8:0], s.pend} : {s.pend, s.din_s2[8:0]};
          mem_we    = 1'b1;
          n.pend_v  = 1'b0;
        end
      end
      else if (iw9)
      begin
        mem_wdata = {9'h000, s.din_s2[8:0]};
        mem_we    = 1'b1;
      end
      else
      begin
        mem_wdata = s.din_s2;
        mem_we    = 1'b1;
      end
    end
    if (mem_we)
    begin
      wr_new = PW'(s.wr_ptr + PW'(1));
    end
    wcnt_new = CW'(PW'(wr_new - to_bin(s.rg2)));

    //////////////////////////////////////////////////////////////////////////
    // Read side
    rbase = to_bin(s.wg2);
    rcnt  = CW'(PW'(rbase - s.rd_ptr));
    word  = mem[s.rd_ptr[AW-1:0]];
    if (split)
    begin
      fmt = (s.rd_half ^ be) ? {9'h000, word[8:0]} : {9'h000, word[17:9]};
      adv = s.rd_half;
    end
    else if (ow9)
    begin
      fmt = {9'h000, word[8:0]};
      adv = 1'b1;
    end
    else if (be & ~iw9)
    begin
      fmt = {word[8:0], word[17:9]};
      adv = 1'b1;
    end
    else
    begin
      fmt = word;
      adv = 1'b1;
    end

    pop      = 1'b0;
    consume  = 1'b0;
    outv_new = s.out_v;
    if (redge && !rst_fifo)
    begin
      if (!fw)
      begin
        pop = ~s.ren_s[1] & s.empty_n & (rcnt != '0);
      end
      else
      begin
        // Output register reloads in the same edge that the reader empties it
        consume = ~s.ren_s[1] & s.out_v;
        if (s.avail && (!s.out_v || consume))
        begin
          pop      = 1'b1;
          outv_new = 1'b1;
        end
        else if (consume)
        begin
          outv_new = 1'b0;
        end
      end
    end
    rd_new = s.rd_ptr;
    if (pop)
    begin
      n.data_out = fmt;
      n.rd_half  = split & ~s.rd_half;
      if (adv)
      begin
        rd_new = PW'(s.rd_ptr + PW'(1));
      end
    end
    n.out_v   = outv_new;
    rcnt_new  = CW'(PW'(rbase - rd_new));
    n.wr_ptr  = wr_new;
    n.rd_ptr  = rd_new;
    n.wr_gray = to_gray(wr_new);
    n.rd_gray = to_gray(rd_new);

    //////////////////////////////////////////////////////////////////////////
    // Flags
    if (wedge)
    begin
      if (!fw)
      begin
        n.full_n = wcnt_new < cap;
      end
      else
      begin
        n.ir_n = ~(wcnt_new < cap);
      end
      if (synct)
      begin
        n.af_n = wcnt_new < af_thr;
      end
    end
    if (redge)
    begin
      if (!fw)
      begin
        n.empty_n = rcnt_new != '0;
      end
      else
      begin
        n.avail = rcnt_new != '0;
        n.or_n  = ~outv_new;
      end
      if (synct)
      begin
        n.ae_n = (rcnt_new + {{(CW-1){1'b0}}, outv_new & fw}) > ae_thr;
      end
    end

    // True pointer difference; the output register counts in fall-through
    mcnt = CW'(PW'(wr_new - rd_new));
    tcnt = mcnt + {{(CW-1){1'b0}}, outv_new & fw};
    if (wedge && (tcnt > half + fw_c))
    begin
      n.hf_n = 1'b0;
    end
    if (redge && !(tcnt > half + fw_c))
    begin
      n.hf_n = 1'b1;
    end
    if (!synct)
    begin
      if (redge && (tcnt <= ae_thr))
      begin
        n.ae_n = 1'b0;
      end
      else if (wedge && (tcnt > ae_thr))
      begin
        n.ae_n = 1'b1;
      end
      if (wedge && (mcnt >= af_thr))
      begin
        n.af_n = 1'b0;
      end
      else if (redge && (mcnt < af_thr))
      begin
        n.af_n = 1'b1;
      end
    end

    // Either reset empties the FIFO; only master reset reloads the modes
    if (rst_fifo)
    begin
      n.wr_ptr  = '0;
      n.rd_ptr  = '0;
      n.wr_gray = '0;
      n.rd_gray = '0;
      n.wg1     = '0;
      n.wg2     = '0;
      n.rg1     = '0;
      n.rg2     = '0;
      n.pend_v  = 1'b0;
      n.rd_half = 1'b0;
      n.out_v   = 1'b0;
      n.avail   = 1'b0;
      n.empty_n = 1'b0;
      n.full_n  = 1'b1;
      n.or_n    = 1'b1;
      n.ir_n    = 1'b0;
      n.hf_n    = 1'b1;
      n.ae_n    = 1'b0;
      n.af_n    = 1'b1;
      if (!s.mrs_s[1])
      begin
        n.act = s.ctrl;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // APB slave: answers in the first access cycle
    hit = (paddr == fifo_flags_pkg::ADDR_CTRL) || (paddr == fifo_flags_pkg::ADDR_OFFSET) ||
          (paddr == fifo_flags_pkg::ADDR_STATUS);
    rd_mux = 32'h00000000;
    case (paddr)
      fifo_flags_pkg::ADDR_CTRL:
        rd_mux[fifo_flags_pkg::CTRL_W-1:0] = s.ctrl;
      fifo_flags_pkg::ADDR_OFFSET:
        rd_mux = {s.f_ofs, s.e_ofs};
      fifo_flags_pkg::ADDR_STATUS:
      begin
        rd_mux[fifo_flags_pkg::ST_EMPTY_N] = s.empty_n;
        rd_mux[fifo_flags_pkg::ST_FULL_N]  = s.full_n;
        rd_mux[fifo_flags_pkg::ST_OR_N]    = s.or_n;
        rd_mux[fifo_flags_pkg::ST_IR_N]    = s.ir_n;
        rd_mux[fifo_flags_pkg::ST_HF_N]    = s.hf_n;
        rd_mux[fifo_flags_pkg::ST_AE_N]    = s.ae_n;
        rd_mux[fifo_flags_pkg::ST_AF_N]    = s.af_n;
        rd_mux[fifo_flags_pkg::ST_CNT_LSB +: 16] = 16'(mcnt);
      end
      default:
        rd_mux = 32'h00000000;
    endcase
    n.pready  = psel & ~penable;
    n.pslverr = psel & ~penable & ~hit;
    if (psel && !penable)
    begin
      n.prdata = pwrite ? 32'h00000000 : rd_mux;
    end
    if (psel && penable && s.pready && pwrite && !s.pslverr)
    begin
      if (paddr == fifo_flags_pkg::ADDR_CTRL)
      begin
        n.ctrl = pwdata[fifo_flags_pkg::CTRL_W-1:0];
      end
      if (paddr == fifo_flags_pkg::ADDR_OFFSET)
      begin
        n.e_ofs = pwdata[fifo_flags_pkg::OFS_E_LSB +: fifo_flags_pkg::OFS_W];
        n.f_ofs = pwdata[fifo_flags_pkg::OFS_F_LSB +: fifo_flags_pkg::OFS_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s         <= '0;
      s.wclk_s  <= 3'h0;
      s.mrs_s   <= 2'h0;
      s.prs_s   <= 2'h0;
      s.wen_s   <= 2'h3;
      s.ren_s   <= 2'h3;
      s.ctrl    <= fifo_flags_pkg::CTRL_RST;
      s.act     <= fifo_flags_pkg::CTRL_RST;
      s.e_ofs   <= fifo_flags_pkg::EMPTY_OFS_RST;
      s.f_ofs   <= fifo_flags_pkg::FULL_OFS_RST;
      s.empty_n <= 1'b0;
      s.full_n  <= 1'b1;
      s.or_n    <= 1'b1;
      s.ir_n    <= 1'b0;
      s.hf_n    <= 1'b1;
      s.ae_n    <= 1'b0;
      s.af_n    <= 1'b1;
    end
    else if (clk_en)
    begin
      s <= n;
    end
  end

  // Storage has no reset: contents are dead until pointers pass them
  always_ff @(posedge pclk)
  begin
    if (clk_en && mem_we)
    begin
      mem[s.wr_ptr[AW-1:0]] <= mem_wdata;
    end
  end

  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign data_out       = s.data_out;
  assign empty_n        = s.empty_n;
  assign full_n         = s.full_n;
  assign output_ready_n = s.or_n;
  assign input_ready_n  = s.ir_n;
  assign half_full_n    = s.hf_n;
  assign almost_empty_n = s.ae_n;
  assign almost_full_n  = s.af_n;

endmodule // fifo_flags_core

`default_nettype wire

// ===== testbench/fifo_flags_monitor.sv
// Port-level concurrent checks for the FIFO status-flag core
`default_nettype none

module fifo_flags_monitor #(
  parameter int DEPTH = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        master_reset_n,
  input wire logic        empty_n,
  input wire logic        full_n,
  input wire logic        output_ready_n,
  input wire logic        input_ready_n,
  input wire logic        half_full_n,
  input wire logic        almost_empty_n
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Eight cycles cover the pin synchroniser plus the flag register
  sequence mreset_held;
    (!master_reset_n && clk_en) [*8];
  endsequence

  sequence setup_phase;
    psel && !penable;
  endsequence

  a_apb_answer: assert property (setup_phase |=> pready)
    else $error("No answer in the first access cycle");
  a_answer_in_access: assert property (pready |-> psel && penable)
    else $error("Answer outside an access phase");
  a_pready_single: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle");
  a_slverr_paired: assert property (pslverr |-> pready)
    else $error("Error response without ready");
  a_unmapped_error: assert property ((setup_phase and (paddr > 12'h008)) |=> pslverr)
    else $error("Unmapped address not refused");
  a_mode_standard: assert property (empty_n || !full_n |-> output_ready_n && !input_ready_n)
    else $error("Fall-through flags active in standard mode");
  a_mode_fallthrough: assert property (!output_ready_n || input_ready_n |-> !empty_n && full_n)
    else $error("Standard flags active in fall-through mode");
  a_mreset_flags: assert property (mreset_held |-> half_full_n && !almost_empty_n && full_n && !empty_n)
    else $error("Flags not at reset values during master reset");

endmodule // fifo_flags_monitor

bind fifo_flags_core fifo_flags_monitor #(.DEPTH(DEPTH)) u_monitor (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .master_reset_n(master_reset_n), .empty_n(empty_n),
  .full_n(full_n), .output_ready_n(output_ready_n), .input_ready_n(input_ready_n),
  .half_full_n(half_full_n), .almost_empty_n(almost_empty_n)
);

`default_nettype wire

// ===== testbench/fifo_flags_partner.sv
// Writer and reader logic facing the FIFO pins, each on its own clock
`default_nettype none

module fifo_flags_partner (
  output logic        write_clock,
  output logic        read_clock,
  output logic        write_enable_n,
  output logic        read_enable_n,
  output logic [17:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Low phase of either clock; raise it to play a slow far side
  int idle_ns = 13;

  initial
  begin
    write_clock = 1'b0;
    read_clock = 1'b0;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    data_in = 18'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clocks pulse only inside a transfer or an idle tick
  task automatic wr_tick(input logic en, input logic [17:0] d);
  begin
    write_enable_n = ~en;
    data_in = d;
    #(idle_ns);
    write_clock = 1'b1;
    // High phase outlasts the pin synchroniser, which samples data late
    #25;
    write_clock = 1'b0;
    write_enable_n = 1'b1;
    data_in = ~d;
    #(idle_ns);
  end
  endtask

  task automatic rd_tick(input logic en);
  begin
    read_enable_n = ~en;
    #(idle_ns);
    read_clock = 1'b1;
    #25;
    read_clock = 1'b0;
    read_enable_n = 1'b1;
    #(idle_ns);
  end
  endtask

endmodule // fifo_flags_partner

`default_nettype wire

// ===== testbench/fifo_status_flags_bus_matching_test.sv
// Self-checking bench for the FIFO status-flag and bus-matching core
`default_nettype none

module fifo_status_flags_bus_matching_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DEPTH = 8;
  localparam int OFS = 2;
  localparam logic [8:0] BYTE_A = 9'h1a5;
  localparam logic [8:0] BYTE_B = 9'h05a;
  // Last run covers synchronous almost flags with the output register counted
  localparam logic [4:0] RUN_CTRL [5] = '{5'h00, 5'h02, 5'h01, 5'h18, 5'h03};
  // Empty, full, half-full and almost-empty: the flags that move on one edge
  localparam logic [31:0] EDGE_MASK = 32'h0000_0033;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        master_reset_n = 1'b1;
  logic        partial_reset_n = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        write_clock, read_clock, write_enable_n, read_enable_n;
  logic [17:0] data_in, data_out;
  logic        empty_n, full_n, output_ready_n, input_ready_n, half_full_n, almost_empty_n, almost_full_n;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cap, c;
  bit          f, s, nine;

  always #2 pclk = ~pclk;

  fifo_flags_core #(.DEPTH(DEPTH)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_clock(write_clock), .read_clock(read_clock), .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n), .data_in(data_in), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .data_out(data_out), .empty_n(empty_n), .full_n(full_n),
    .output_ready_n(output_ready_n), .input_ready_n(input_ready_n), .half_full_n(half_full_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n)
  );

  fifo_flags_partner u_far (
    .write_clock(write_clock), .read_clock(read_clock), .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n), .data_in(data_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
  begin
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
  begin
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic st;
    apb(1'b0, fifo_flags_pkg::ADDR_STATUS, 32'h0);
  endtask

  task automatic chk_out(input logic [17:0] w);
  begin
    @(negedge pclk);
    check({14'h0, data_out}, {14'h0, w});
  end
  endtask

  task automatic settle;
    repeat (3)
    begin
      u_far.wr_tick(1'b0, 18'h0);
      u_far.rd_tick(1'b0);
    end
  endtask

  function automatic logic [17:0] pat(input int i);
    return nine ? {9'h0, 9'(i + 1)} : {9'(i + 64), 9'(i + 1)};
  endfunction

  function automatic logic [31:0] exp_st(input int k);
    int mem;
  begin
    mem = (f && k > 0) ? k - 1 : k;
    return {mem[15:0], 9'h0, mem < cap - OFS, k > OFS + f, k <= cap / 2 + f, f && k > cap,
            !f || k == 0, f || k < cap, !f && k > 0};
  end
  endfunction

  task automatic mrst(input logic [4:0] ctrl);
  begin
    f = ctrl[0];
    s = ctrl[1];
    nine = ctrl[3] && ctrl[4];
    cap = nine ? 2 * DEPTH : DEPTH;
    c = 0;
    apb(1'b1, fifo_flags_pkg::ADDR_CTRL, {27'h0, ctrl});
    master_reset_n <= 1'b0; // Modes are loaded while master reset is low
    repeat (8) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, fifo_flags_pkg::ADDR_OFFSET, 32'h0002_0002);
    apb(1'b0, fifo_flags_pkg::ADDR_CTRL, 32'h0);
    check(rd, {27'h0, ctrl});
  end
  endtask

  // One write or read, then the flags just after that edge (standard mode only) and once both sides have ticked
  task automatic op(input bit wr, input int i);
    logic [31:0] o;
    logic [31:0] keep;
    logic [6:0]  pins;
  begin
    o = exp_st(c);
    if (wr)
    begin
      u_far.wr_tick(1'b1, pat(i));
      c = (c < cap + f) ? c + 1 : c;
    end
    else
    begin
      if (f) chk_out(pat(i));
      u_far.rd_tick(1'b1);
      if (!f) chk_out(pat(i));
      c = c - 1;
    end
    // Flags owned by the other side's clock keep their old value
    keep = wr ? (s ? 32'h21 : 32'h01) : 32'h02;
    st();
    if (!f) check(rd & EDGE_MASK, ((exp_st(c) & ~keep) | (o & keep)) & EDGE_MASK);
    settle();
    st();
    check(rd, exp_st(c));
    // The flag pins must agree with the status word, sampled mid-cycle
    @(negedge pclk);
    pins = {almost_full_n, almost_empty_n, half_full_n, input_ready_n, output_ready_n, full_n, empty_n};
    check({25'h0, pins}, exp_st(c) & 32'h7f);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, fifo_flags_pkg::ADDR_CTRL, 32'h0);
    check(rd, {27'h0, fifo_flags_pkg::CTRL_RST});
    apb(1'b0, fifo_flags_pkg::ADDR_OFFSET, 32'h0);
    check(rd, {fifo_flags_pkg::FULL_OFS_RST, fifo_flags_pkg::EMPTY_OFS_RST});
    st();
    check(rd, 32'h0000_0056);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'h0);
    $display("Test registers done");
    for (int r = 0; r < 5; r++)
    begin
      mrst(RUN_CTRL[r]);
      for (int i = 0; i <= cap + f; i++) op(1'b1, i); // The last write meets a full FIFO
      for (int i = 0; c > 0; i++) op(1'b0, i); // Reads stop once empty
      $display("Test fill and drain %0d done", r);
    end
    for (int b = 0; b < 6; b++)
    begin
      mrst({b >= 4, b == 2 || b == 3, b[0], 2'b00});
      if (b == 2 || b == 3)
      begin
        u_far.wr_tick(1'b1, {9'h0, BYTE_A});
        u_far.wr_tick(1'b1, {9'h0, BYTE_B});
      end
      else
        u_far.wr_tick(1'b1, {BYTE_A, BYTE_B});
      settle();
      u_far.rd_tick(1'b1);
      if (b >= 4)
      begin
        chk_out({9'h0, b[0] ? BYTE_B : BYTE_A});
        settle();
        u_far.rd_tick(1'b1);
        chk_out({9'h0, b[0] ? BYTE_A : BYTE_B});
      end
      else
        chk_out(b[0] ? {BYTE_B, BYTE_A} : {BYTE_A, BYTE_B});
    end
    $display("Test byte order done");
    mrst(5'h01);
    for (int i = 0; i < 3; i++) u_far.wr_tick(1'b1, pat(i));
    partial_reset_n <= 1'b0;
    repeat (8) @(posedge pclk);
    partial_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    settle();
    st();
    check(rd, exp_st(0));
    op(1'b1, 7);
    $display("Test partial reset done");
    report_and_stop();
  end

  // Whole run needs about 46 us; this cuts a hang short
  initial
  begin
    #200us;
    fail_count++;
    report_and_stop();
  end

endmodule // fifo_status_flags_bus_matching_test

`default_nettype wire
